// *** logic/sdlc_pkg.sv ***
package sdlc_pkg;
	localparam int          WORD_BITS     = 16;
	localparam int          SEG_BITS      = 4;
	localparam int          SEG_COUNT     = 15;
	localparam int          LADDER_BITS   = 12;
	localparam logic [15:0] MIDSCALE_CODE = 16'h8000;
	localparam logic [4:0]  BIT_COUNT_MAX = 5'h10;
	localparam int          SYNC_STAGES   = 3;
endpackage

// *** logic/sdlc_word_reg.sv ***
`timescale 1ns/1ps
// Word holding register with load enable; read data come from the register
module sdlc_word_reg #(
	parameter int          WIDTH = 16,
	parameter logic [15:0] INIT  = 16'h8000
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_load,
	input  wire logic [WIDTH-1:0] i_data,
	output logic      [WIDTH-1:0] o_data
);
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_data <= INIT[WIDTH-1:0];
		end else if (i_load) begin
			o_data <= i_data;
		end
	end
endmodule // sdlc_word_reg

// *** logic/sdlc_dac_ctrl.sv ***
// Contract
// - Clear falling edge forces output to analog ground; registers keep contents.
// - Load low copies input register into converter register.
// - With load held low, update happens on frame select rising edge.
// - Frame select low enables shifting; high blocks the shift register.
// - After frame select falls, 16 falling clock edges carry one word.
// - Serial input sampled and shifted on each serial clock falling edge.
// - Shift register is exactly 16 bits, one code per frame.
// - Serial output is open drain; only pulls low, external pull-up.
// - Serial output carries shift register out for cascading devices.
// - Serial output allows controller readback of register data.
// - Power-down low enters low power; release returns to normal.
// - Clock and data toggling with frame select high changes nothing.
// - Offset binary code; 8000H is zero volts.
// - Top four code bits thermometer-decode into 15 segment switches.
// - Low 12 code bits drive ladder switches directly, bit 0 upward.
// - Power-on reset holds output at zero volts before any write.
// - Power-up loads shift and converter registers with midscale.
// - Transfer end moves shift register into input register automatically.
// - Load high during shifting: update on load falling edge after frame ends.
// - Extra clocks ripple data out; output repeats input delayed 16 clocks.
`timescale 1ns/1ps
module sdlc_dac_ctrl (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_serial_clk,
	input  wire logic        i_frame_sel_n,
	input  wire logic        i_serial_in,
	input  wire logic        i_output_load_n,
	input  wire logic        i_output_clear_n,
	input  wire logic        i_power_down_n,
	input  wire logic        i_serial_out,
	output logic             o_serial_out,
	output logic             o_serial_out_oe,
	output logic [14:0]      o_segment_switches,
	output logic [11:0]      o_ladder_switches,
	output logic             o_output_grounded,
	output logic             o_power_down,
	output logic [15:0]      o_dac_code
);

	////////////////////////////////////////////////////////////////////////////////
	// Three-stage pin synchronisers; a change counts when stages two and three agree

	logic [2:0] sclk_sync_q;
	logic [2:0] fsel_sync_q;
	logic [2:0] din_sync_q;
	logic [2:0] load_sync_q;
	logic [2:0] clear_sync_q;
	logic [2:0] pwr_sync_q;
	logic       sclk_q;
	logic       fsel_n_q;
	logic       din_q;
	logic       load_n_q;
	logic       clear_n_q;
	logic       pwr_n_q;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			// Serial clock idles high; matching reset avoids a false edge
			sclk_sync_q  <= 3'h7;
			fsel_sync_q  <= 3'h7;
			din_sync_q   <= 3'h0;
			load_sync_q  <= 3'h7;
			clear_sync_q <= 3'h7;
			pwr_sync_q   <= 3'h7;
		end else begin
			sclk_sync_q  <= {sclk_sync_q[1:0], i_serial_clk};
			fsel_sync_q  <= {fsel_sync_q[1:0], i_frame_sel_n};
			din_sync_q   <= {din_sync_q[1:0], i_serial_in};
			load_sync_q  <= {load_sync_q[1:0], i_output_load_n};
			clear_sync_q <= {clear_sync_q[1:0], i_output_clear_n};
			pwr_sync_q   <= {pwr_sync_q[1:0], i_power_down_n};
		end
	end

	// Filtered levels: move only when stages two and three agree
	function automatic logic sdlc_filt(input logic [2:0] s, input logic cur);
		sdlc_filt = (s[1] == s[2]) ? s[2] : cur;
	endfunction

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sclk_q    <= 1'b1;
			fsel_n_q  <= 1'b1;
			din_q     <= 1'b0;
			load_n_q  <= 1'b1;
			clear_n_q <= 1'b1;
			pwr_n_q   <= 1'b1;
		end else begin
			sclk_q    <= sdlc_filt(sclk_sync_q, sclk_q);
			fsel_n_q  <= sdlc_filt(fsel_sync_q, fsel_n_q);
			din_q     <= sdlc_filt(din_sync_q, din_q);
			load_n_q  <= sdlc_filt(load_sync_q, load_n_q);
			clear_n_q <= sdlc_filt(clear_sync_q, clear_n_q);
			pwr_n_q   <= sdlc_filt(pwr_sync_q, pwr_n_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Edge detection on filtered levels

	logic sclk_d1_q;
	logic fsel_d1_q;
	logic load_d1_q;
	logic clear_d1_q;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sclk_d1_q  <= 1'b1;
			fsel_d1_q  <= 1'b1;
			load_d1_q  <= 1'b1;
			clear_d1_q <= 1'b1;
		end else begin
			sclk_d1_q  <= sclk_q;
			fsel_d1_q  <= fsel_n_q;
			load_d1_q  <= load_n_q;
			clear_d1_q <= clear_n_q;
		end
	end

	logic sclk_fall;
	logic fsel_rise;
	logic load_fall;
	logic clear_fall;
	logic shift_en;

	assign sclk_fall  = sclk_d1_q & ~sclk_q;
	assign fsel_rise  = ~fsel_d1_q & fsel_n_q;
	assign load_fall  = load_d1_q & ~load_n_q;
	assign clear_fall = clear_d1_q & ~clear_n_q;
	// Shifting only while frame select is low; clock and data ignored otherwise
	assign shift_en  = sclk_fall & ~fsel_n_q;

	////////////////////////////////////////////////////////////////////////////////
	// Frame state machine

	typedef enum logic [1:0] {
		SDLC_IDLE  = 2'b01,
		SDLC_FRAME = 2'b10
	} sdlc_state_t;

	sdlc_state_t state_q;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_q <= SDLC_IDLE;
		end else begin
			case (state_q)
				SDLC_IDLE: begin
					if (!fsel_n_q) begin
						state_q <= SDLC_FRAME;
					end
				end
				SDLC_FRAME: begin
					if (fsel_n_q) begin
						state_q <= SDLC_IDLE;
					end
				end
				default: begin
					state_q <= SDLC_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shift register and bit counter

	logic [15:0] shift_q;
	logic [4:0]  count_q;
	logic        frame_full;

	assign frame_full = (count_q == sdlc_pkg::BIT_COUNT_MAX);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			shift_q <= sdlc_pkg::MIDSCALE_CODE;
		end else if (shift_en) begin
			shift_q <= {shift_q[14:0], din_q};
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			count_q <= 5'h00;
		end else if (state_q == SDLC_IDLE && !fsel_n_q) begin
			count_q <= 5'h00;
		end else if (shift_en && !frame_full) begin
			count_q <= count_q + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input and converter registers

	logic        input_load;
	logic        dac_load;
	logic [15:0] input_word;
	logic [15:0] dac_word;

	// Complete word moves to the input register at frame end; partial word dropped
	assign input_load = fsel_rise & (state_q == SDLC_FRAME) & frame_full;

	// Synchronous mode updates at frame end; asynchronous on load fall while idle
	assign dac_load = (input_load & ~load_n_q)
		| (load_fall & fsel_n_q & ~input_load);

	sdlc_word_reg #(
		.WIDTH (sdlc_pkg::WORD_BITS),
		.INIT  (sdlc_pkg::MIDSCALE_CODE)
	) u_input_reg (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_load  (input_load),
		.i_data  (shift_q),
		.o_data  (input_word)
	);

	// Synchronous path takes the fresh shift word directly
	sdlc_word_reg #(
		.WIDTH (sdlc_pkg::WORD_BITS),
		.INIT  (sdlc_pkg::MIDSCALE_CODE)
	) u_dac_reg (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_load  (dac_load),
		.i_data  (input_load ? shift_q : input_word),
		.o_data  (dac_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clear and power-down state

	logic grounded_q;
	logic sleep_q;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			grounded_q <= 1'b1;
		end else if (clear_fall) begin
			grounded_q <= 1'b1;
		end else if (dac_load) begin
			grounded_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sleep_q <= 1'b0;
		end else begin
			sleep_q <= ~pwr_n_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Switch decoding

	function automatic logic [14:0] sdlc_thermo(input logic [3:0] v);
		logic [14:0] t;
		t = 15'h0000;
		for (int i = 0; i < sdlc_pkg::SEG_COUNT; i++) begin
			t[i] = (32'(v) > i);
		end
		sdlc_thermo = t;
	endfunction

	logic [15:0] eff_code;

	// Grounded output shown as midscale code, which is zero volts
	assign eff_code = grounded_q ? sdlc_pkg::MIDSCALE_CODE : dac_word;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_segment_switches <= sdlc_thermo(sdlc_pkg::MIDSCALE_CODE[15:12]);
			o_ladder_switches  <= sdlc_pkg::MIDSCALE_CODE[11:0];
			o_dac_code         <= sdlc_pkg::MIDSCALE_CODE;
			o_output_grounded  <= 1'b1;
			o_power_down       <= 1'b0;
		end else begin
			o_segment_switches <= sdlc_thermo(eff_code[15:12]);
			o_ladder_switches  <= eff_code[11:0];
			o_dac_code         <= dac_word;
			o_output_grounded  <= grounded_q;
			o_power_down       <= sleep_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Open-drain serial output: bit 15 leaves, drive low only

	logic pull_low_q;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pull_low_q <= 1'b0;
		end else if (!fsel_n_q) begin
			pull_low_q <= ~shift_q[15];
		end else begin
			pull_low_q <= 1'b0;
		end
	end

	assign o_serial_out    = 1'b0;
	assign o_serial_out_oe = pull_low_q;

endmodule // sdlc_dac_ctrl

// *** testbench/sdlc_dac_ctrl_chk.sv ***
`timescale 1ns/1ps
module sdlc_dac_ctrl_chk (
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_frame_sel_n,
	input wire logic        i_output_load_n,
	input wire logic        i_output_clear_n,
	input wire logic        i_power_down_n,
	input wire logic        o_serial_out,
	input wire logic        o_serial_out_oe,
	input wire logic [14:0] o_segment_switches,
	input wire logic [11:0] o_ladder_switches,
	input wire logic        o_output_grounded,
	input wire logic        o_power_down,
	input wire logic [15:0] o_dac_code
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic [14:0] therm;
	assign therm = 15'((16'h1 << o_dac_code[15:12]) - 16'h1);
	sequence s_settled;
		($stable(o_dac_code) && $stable(o_output_grounded)) [*2];
	endsequence
	sequence s_idle;
		(i_frame_sel_n && $stable(i_output_load_n)) [*8];
	endsequence
	a_seg_thermo: assert property (s_settled ##0 !o_output_grounded |->
		o_segment_switches == therm) else $error("segment decode wrong");
	a_ladder_bits: assert property (s_settled ##0 !o_output_grounded |->
		o_ladder_switches == o_dac_code[11:0]) else $error("ladder bits wrong");
	a_ground_mid: assert property (s_settled ##0 o_output_grounded |->
		o_segment_switches == 15'h00FF && o_ladder_switches == 12'h000)
		else $error("grounded output not at midscale");
	a_reset_mid: assert property ($rose(i_rst_n) |-> o_output_grounded &&
		o_dac_code == sdlc_pkg::MIDSCALE_CODE) else $error("reset code wrong");
	a_clear_ground: assert property ($fell(i_output_clear_n) |->
		##[1:10] o_output_grounded) else $error("clear did not ground");
	a_clear_keep: assert property (s_idle ##0 $fell(i_output_clear_n) |=>
		$stable(o_dac_code) [*6]) else $error("clear changed code");
	a_idle_frozen: assert property (s_idle |=> $stable(o_dac_code))
		else $error("code changed while idle");
	a_pwr_enter: assert property ($fell(i_power_down_n) |-> ##[1:10] o_power_down)
		else $error("power-down not entered");
	a_pwr_leave: assert property ($rose(i_power_down_n) |-> ##[1:10] !o_power_down)
		else $error("power-down not left");
	a_drain_only: assert property (o_serial_out == 1'b0)
		else $error("serial out drives high");
	a_oe_idle: assert property (i_frame_sel_n [*8] |-> !o_serial_out_oe)
		else $error("serial out pulled outside frame");
endmodule // sdlc_dac_ctrl_chk
bind sdlc_dac_ctrl sdlc_dac_ctrl_chk i_chk (.i_clk, .i_rst_n, .i_frame_sel_n,
	.i_output_load_n, .i_output_clear_n, .i_power_down_n, .o_serial_out,
	.o_serial_out_oe, .o_segment_switches, .o_ladder_switches, .o_output_grounded,
	.o_power_down, .o_dac_code);

// *** testbench/sdlc_host_model.sv ***
`timescale 1ns/1ps
module sdlc_host_model (
	output logic      o_sclk,
	output logic      o_frame_n,
	output logic      o_data,
	input  wire logic i_oe,
	output logic      o_wire
);
	logic rx[$];
	// Pull-up wins unless the device sinks the line
	assign o_wire = !i_oe;
	initial begin
		o_sclk = 1'b1;
		o_frame_n = 1'b1;
		o_data = 1'b0;
	end
	// MSB first; hold keeps the frame closed and only toggles the lines
	task automatic xfer(input logic [31:0] d, input int n, input bit hold);
		rx.delete();
		o_frame_n = hold;
		#40;
		for (int i = n - 1; i >= 0; i--) begin
			o_data = d[i];
			// Bench link runs faster than the host limit; oversampling tolerates it
			#32;
			if (i < n - 1) rx.push_back(o_wire);
			o_sclk = 1'b0;
			#32;
			o_sclk = 1'b1;
		end
		#32;
		rx.push_back(o_wire);
		o_data = !o_data;
		#8;
		o_frame_n = 1'b1;
	endtask
endmodule // sdlc_host_model

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic i_clk = 0, i_rst_n = 0, ld_n = 1, clear_n = 1, pwr_n = 1;
	logic sclk, fs_n, sdi, oe, sw, so, gnd, pdo;
	logic [14:0] seg;
	logic [11:0] lad;
	logic [15:0] code;
	logic [15:0] m_shift = 16'h8000, m_in = 16'h8000, m_conv = 16'h8000;
	bit m_gnd = 1, rb = 1;
	int mismatches = 0, checks = 0;
	always #2.5 i_clk = ~i_clk;
	sdlc_host_model i_sdlc_host_model (.o_sclk(sclk), .o_frame_n(fs_n), .o_data(sdi),
		.i_oe(oe), .o_wire(sw));
	sdlc_dac_ctrl i_sdlc_dac_ctrl (.i_clk, .i_rst_n, .i_serial_clk(sclk),
		.i_frame_sel_n(fs_n), .i_serial_in(sdi), .i_output_load_n(ld_n),
		.i_output_clear_n(clear_n), .i_power_down_n(pwr_n), .i_serial_out(sw),
		.o_serial_out(so), .o_serial_out_oe(oe), .o_segment_switches(seg),
		.o_ladder_switches(lad), .o_output_grounded(gnd), .o_power_down(pdo),
		.o_dac_code(code));
	////////////////////////////////////////
	task automatic cmp_word(input logic [15:0] e, input logic [15:0] a);
		checks++;
		if (a !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t exp=%h act=%h", $time, e, a);
		end
	endtask
	task automatic cmp_bit(input logic e, input logic a);
		cmp_word({15'h0, e}, {15'h0, a});
	endtask
	task automatic chk_out();
		logic [15:0] e;
		e = m_gnd ? 16'h8000 : m_conv;
		cmp_word(m_conv, code);
		cmp_bit(m_gnd, gnd);
		cmp_word({1'b0, 15'((16'h1 << e[15:12]) - 16'h1)}, {1'b0, seg});
		cmp_word({4'h0, e[11:0]}, {4'h0, lad});
	endtask
	task automatic frame(input logic [31:0] d, input int n, input bit hold);
		@(negedge i_clk);
		i_sdlc_host_model.xfer(d, n, hold);
		if (!hold) begin
			for (int k = 0; k < n; k++) begin
				m_shift = {m_shift[14:0], d[n-1-k]};
				if (rb) cmp_bit(m_shift[15], i_sdlc_host_model.rx[k]);
			end
			if (n >= 16) begin
				m_in = m_shift;
				if (!ld_n) begin
					m_conv = m_in;
					m_gnd = 0;
				end
			end
		end
		repeat (12) @(negedge i_clk);
		chk_out();
	endtask
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		#100us;
		mismatches++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'h2cfa));
		repeat (6) @(negedge i_clk);
		i_rst_n = 1;
		repeat (8) @(negedge i_clk);
		chk_out();
		ld_n = 0;
		m_conv = m_in;
		m_gnd = 0;
		repeat (12) @(negedge i_clk);
		chk_out();
		for (int i = 0; i < 16; i++) frame((i << 12) | ($urandom & 32'hFFF), 16, 0);
		rb = 0;
		frame($urandom, 10, 0);
		frame($urandom, 16, 0);
		rb = 1;
		frame($urandom, 24, 0);
		frame($urandom, 20, 1);
		ld_n = 1;
		frame($urandom, 16, 0);
		@(negedge i_clk);
		ld_n = 0;
		m_conv = m_in;
		m_gnd = 0;
		repeat (12) @(negedge i_clk);
		chk_out();
		clear_n = 0;
		m_gnd = 1;
		repeat (12) @(negedge i_clk);
		chk_out();
		clear_n = 1;
		frame($urandom, 16, 0);
		pwr_n = 0;
		repeat (12) @(negedge i_clk);
		cmp_bit(1'b1, pdo);
		pwr_n = 1;
		repeat (12) @(negedge i_clk);
		cmp_bit(1'b0, pdo);
		cmp_bit(1'b0, so);
		print_verdict();
	end
endmodule // testbench
